/* dv/host_model.sv */
// controller model driving data, shift clock and strobe pins
// assumes the bench clock; pins change on its falling edges
`timescale 1ns/1ns
module host_model (
    // bench clock
    input  wire logic clock,
    // controller pins
    output logic      serialIn,
    output logic      shiftClock,
    output logic      strobe
);
    initial begin
        serialIn   = 1'b0;
        shiftClock = 1'b0;
        strobe     = 1'b0;
    end
    task automatic waitFall(input int n);
        repeat (n) @(negedge clock);
    endtask : waitFall
    // first bit sent ends in the last stage; half sets prompt or slow edges
    task automatic send(input logic [7:0] b, input int half);
        for (int k = 7; k >= 0; k--) begin
            serialIn = b[k];
            waitFall(half);
            shiftClock = 1'b1;
            waitFall(half);
            shiftClock = 1'b0;
        end
        // data is not held past the last bit
        serialIn = ~serialIn;
    endtask : send
    task automatic pulse(input int n);
        strobe = 1'b1;
        waitFall(n);
        strobe = 1'b0;
    endtask : pulse
endmodule : host_model

/* dv/shift_store_props.sv */
// pin assertions for the shift-and-store register
// assumes engineHold is low apart from one buffer test
`timescale 1ns/1ns
module shift_store_props #(
    parameter int STAGES     = 8,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              reset_n,
    // pins
    input wire logic              serialIn,
    input wire logic              shift_clock,
    input wire logic              latch_strobe,
    input wire logic              outputEnable,
    input wire logic              engineHold,
    // outputs
    input wire logic              eventReady_q,
    input wire logic              eventLost_q,
    input wire logic [STAGES-1:0] parallel_outputs,
    input wire logic [STAGES-1:0] parallelEnable_n,
    input wire logic              cascade_out_rise,
    input wire logic              cascade_out_fall
);
    logic [5:0] quiet_q;
    // pin-to-output latency only holds once a stalled backlog has drained
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            quiet_q <= 6'h00;
        end else if (engineHold) begin
            quiet_q <= 6'h00;
        end else if (quiet_q != 6'h3F) begin
            quiet_q <= quiet_q + 6'h01;
        end
    end
    wire settled = (quiet_q == 6'h3F);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence fallMoves;
        $changed(cascade_out_fall) && settled;
    endsequence
    sequence riseMoves;
        $changed(cascade_out_rise) && settled;
    endsequence
    chk_float_after_fall: assert property (
        $fell(outputEnable) |-> ##[2:7] parallelEnable_n == '1) else $error("outputs not floated");
    chk_drive_after_rise: assert property (
        $rose(outputEnable) |-> ##[2:7] parallelEnable_n == '0) else $error("outputs not driven");
    chk_float_holds: assert property (
        !outputEnable [*8] |-> parallelEnable_n == '1) else $error("driven while disabled");
    chk_latch_hold: assert property (
        (settled && !latch_strobe) [*8] |=> $stable(parallel_outputs)) else $error("latch moved");
    chk_fall_copies_rise: assert property (
        fallMoves |-> cascade_out_fall == cascade_out_rise) else $error("fall cascade wrong");
    chk_fall_only_cascade: assert property (
        fallMoves |-> $stable(cascade_out_rise) && $stable(parallel_outputs))
        else $error("falling edge moved more");
    chk_rise_on_edge: assert property (
        riseMoves |-> shift_clock && $past(shift_clock, 2)) else $error("rise cascade off edge");
    chk_lost_sticky: assert property (
        eventLost_q |=> eventLost_q) else $error("lost flag cleared");
endmodule : shift_store_props
bind shift_and_store_register shift_store_props #(.STAGES(STAGES), .FIFO_DEPTH(FIFO_DEPTH)) props (
    .clock(clock), .reset_n(reset_n), .serialIn(serialIn), .shift_clock(shift_clock),
    .latch_strobe(latch_strobe), .outputEnable(outputEnable), .engineHold(engineHold),
    .eventReady_q(eventReady_q), .eventLost_q(eventLost_q), .parallel_outputs(parallel_outputs),
    .parallelEnable_n(parallelEnable_n), .cascade_out_rise(cascade_out_rise),
    .cascade_out_fall(cascade_out_fall));

/* dv/tb.sv */
// self-checking bench for the shift-and-store register
// assumes the host model drives the controller pins
`timescale 1ns/1ns
module tb;
    typedef struct {
        int         sel;
        logic [7:0] exp;
    } note_type;
    logic       clock, reset_n, outputEnable, engineHold;
    logic       serialIn, shiftClock, strobe;
    logic       eventReady, eventLost, cascadeRise, cascadeFall;
    logic [7:0] parOut, parEnable_n, prev, cur;
    note_type   noteQ[$];
    int         mismatches, checks;
    event       look;
    string      what[4] = '{"parallel", "enable_n", "cascade", "status"};
    shift_and_store_register dut (.clock(clock), .reset_n(reset_n), .serialIn(serialIn),
        .shift_clock(shiftClock), .latch_strobe(strobe), .outputEnable(outputEnable),
        .engineHold(engineHold), .eventReady_q(eventReady), .eventLost_q(eventLost),
        .parallel_outputs(parOut), .parallelEnable_n(parEnable_n),
        .cascade_out_rise(cascadeRise), .cascade_out_fall(cascadeFall));
    host_model host (.clock(clock), .serialIn(serialIn), .shiftClock(shiftClock),
        .strobe(strobe));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle
    task automatic note(input int sel, input logic [7:0] v);
        noteQ.push_back('{sel, v});
        -> look;
    endtask : note
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    initial begin : monitor
        note_type   n;
        logic [7:0] seen;
        forever begin
            @(look);
            while (noteQ.size() > 0) begin
                n = noteQ.pop_front();
                case (n.sel)
                    0: seen = parOut;
                    1: seen = parEnable_n;
                    2: seen = {6'h00, cascadeFall, cascadeRise};
                    default: seen = {6'h00, eventLost, eventReady};
                endcase
                checks++;
                if (seen !== n.exp) begin
                    mismatches++;
                    $display("wrong value %s expected %h seen %h", what[n.sel], n.exp, seen);
                end
            end
        end
    end
    initial begin
        reset_n      = 1'b0;
        outputEnable = 1'b0;
        engineHold   = 1'b0;
        mismatches   = 0;
        checks       = 0;
        prev         = 8'h00;
        void'($urandom(32'h66EA));
        idle(2);
        reset_n = 1'b1;
        idle(4);
        // shift with strobe low, then strobe; third byte with outputs floating
        for (int i = 0; i < 6; i++) begin
            cur          = 8'($urandom());
            outputEnable = (i != 2);
            host.send(cur, (i % 2) ? 16 : 8);
            idle(10);
            note(0, prev);
            note(2, {6'h00, cur[7], cur[7]});
            host.pulse(6);
            idle(10);
            note(0, cur);
            note(1, outputEnable ? 8'h00 : 8'hFF);
            prev = cur;
            $display("test shift %0d done", i);
        end
        // stalled engine: more edge events than the buffer holds
        engineHold = 1'b1;
        host.send(8'hA5, 4);
        host.send(8'h5A, 4);
        idle(10);
        note(3, 8'h02);
        engineHold = 1'b0;
        for (int t = 0; t < 200 && eventReady !== 1'b1; t++) begin
            idle(1);
        end
        if (eventReady !== 1'b1) begin
            mismatches++;
            idle(1);
            conclude();
        end
        idle(60);
        note(3, 8'h03);
        $display("test buffer done");
        reset_n = 1'b0;
        idle(2);
        note(3, 8'h00);
        note(1, 8'hFF);
        note(0, 8'h00);
        reset_n = 1'b1;
        idle(2);
        note(3, 8'h01);
        $display("test reset done");
        idle(2);
        conclude();
    end
endmodule : tb

/* rtl/event_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
module event_fifo #(
    parameter int WIDTH = shift_store_pkg::EVENT_WIDTH,
    parameter int DEPTH = shift_store_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic    clock,
    input  wire logic    reset_n,
    // filling and draining sides
    event_stream_if.sink   fillSide,
    event_stream_if.source drainSide
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    writePtr_q;
    logic [PW-1:0]    readPtr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    assign fillSide.ready  = (count_q != (PW+1)'(DEPTH));
    assign drainSide.valid = (count_q != '0);
    assign drainSide.data  = mem_q[readPtr_q];
    assign push            = fillSide.valid && fillSide.ready;
    assign pop             = drainSide.valid && drainSide.ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[writePtr_q] <= fillSide.data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            writePtr_q <= '0;
            readPtr_q  <= '0;
        end else begin
            if (push) begin
                writePtr_q <= (writePtr_q == PW'(DEPTH - 1)) ? '0 : writePtr_q + 1'b1;
            end
            if (pop) begin
                readPtr_q <= (readPtr_q == PW'(DEPTH - 1)) ? '0 : readPtr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule : event_fifo

/* rtl/event_stream_if.sv */
// valid/ready carrier for edge events between the sampler and the shift engine
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface event_stream_if #(
    parameter int WIDTH = shift_store_pkg::EVENT_WIDTH
) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : event_stream_if

/* rtl/shift_and_store_register.sv */
// eight-stage serial shift register with strobed latches and floating outputs
// assumes all control pins are asynchronous to clock and are oversampled here;
// the shift clock must stay well below clock / 8 so that each level is seen
`timescale 1ns/1ns
module shift_and_store_register #(
    parameter int STAGES     = shift_store_pkg::STAGE_COUNT,
    parameter int FIFO_DEPTH = shift_store_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // pins from the controller
    input  wire logic              serialIn,
    input  wire logic              shift_clock,
    input  wire logic              latch_strobe,
    input  wire logic              outputEnable,
    // engine stall and buffer status
    input  wire logic              engineHold,
    output logic                   eventReady_q,
    output logic                   eventLost_q,
    // parallel outputs, enable low while driving
    output logic [STAGES-1:0]      parallel_outputs,
    output logic [STAGES-1:0]      parallelEnable_n,
    // cascade outputs
    output logic                   cascade_out_rise,
    output logic                   cascade_out_fall
);
    localparam int W = shift_store_pkg::EVENT_WIDTH;

    // three-flop synchronisers; first flop is read only by the second
    logic [shift_store_pkg::SYNC_DEPTH-1:0] dataSync_q;
    logic [shift_store_pkg::SYNC_DEPTH-1:0] clkSync_q;
    logic [shift_store_pkg::SYNC_DEPTH-1:0] strobeSync_q;
    logic [shift_store_pkg::SYNC_DEPTH-1:0] oeSync_q;
    logic clkLevel_q;
    logic dataLevel_q;
    logic strobeLevel_q;
    logic oeLevel_q;

    function automatic logic settled(input logic [shift_store_pkg::SYNC_DEPTH-1:0] s);
        settled = (s[1] == s[2]);
    endfunction : settled

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dataSync_q   <= shift_store_pkg::SYNC_RESET;
            clkSync_q    <= shift_store_pkg::SYNC_RESET;
            strobeSync_q <= shift_store_pkg::SYNC_RESET;
            oeSync_q     <= shift_store_pkg::SYNC_RESET;
        end else begin
            dataSync_q   <= {dataSync_q[1:0], serialIn};
            clkSync_q    <= {clkSync_q[1:0], shift_clock};
            strobeSync_q <= {strobeSync_q[1:0], latch_strobe};
            oeSync_q     <= {oeSync_q[1:0], outputEnable};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clkLevel_q    <= shift_store_pkg::BIT_RESET;
            dataLevel_q   <= shift_store_pkg::BIT_RESET;
            strobeLevel_q <= shift_store_pkg::BIT_RESET;
            oeLevel_q     <= shift_store_pkg::BIT_RESET;
        end else begin
            if (settled(clkSync_q))    clkLevel_q    <= clkSync_q[2];
            if (settled(dataSync_q))   dataLevel_q   <= dataSync_q[2];
            if (settled(strobeSync_q)) strobeLevel_q <= strobeSync_q[2];
            if (settled(oeSync_q))     oeLevel_q     <= oeSync_q[2];
        end
    end

    // edge and strobe-change events enter the buffer in pin order, so the
    // engine sees shifts and strobe changes in the sequence they happened
    event_stream_if #(.WIDTH(W)) fillSide ();
    event_stream_if #(.WIDTH(W)) drainSide ();

    logic clkNext;
    logic strobeNext;
    logic riseSeen;
    logic fallSeen;
    logic strobeChange;
    logic strobeTrack_q;

    assign clkNext      = settled(clkSync_q) ? clkSync_q[2] : clkLevel_q;
    assign strobeNext   = settled(strobeSync_q) ? strobeSync_q[2] : strobeLevel_q;
    assign riseSeen     = clkNext && !clkLevel_q;
    assign fallSeen     = !clkNext && clkLevel_q;
    assign strobeChange = (strobeNext != strobeTrack_q);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strobeTrack_q <= shift_store_pkg::BIT_RESET;
        end else begin
            strobeTrack_q <= strobeNext;
        end
    end

    always_comb begin
        fillSide.valid                          = riseSeen || fallSeen || strobeChange;
        fillSide.data                           = '0;
        fillSide.data[shift_store_pkg::BIT_RISE]   = riseSeen;
        fillSide.data[shift_store_pkg::BIT_FALL]   = fallSeen;
        // data is sampled at the settled edge; setup is far longer than sync delay
        fillSide.data[shift_store_pkg::BIT_DATA]   = dataLevel_q;
        fillSide.data[shift_store_pkg::BIT_STROBE] = strobeNext;
    end

    event_fifo #(
        .WIDTH (W),
        .DEPTH (FIFO_DEPTH)
    ) eventBuffer (
        .clock     (clock),
        .reset_n   (reset_n),
        .fillSide  (fillSide),
        .drainSide (drainSide)
    );

    // buffer status; an event arriving while full is lost and flagged sticky
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            eventReady_q <= shift_store_pkg::BIT_RESET;
            eventLost_q  <= shift_store_pkg::BIT_RESET;
        end else begin
            eventReady_q <= fillSide.ready;
            if (fillSide.valid && !fillSide.ready) begin
                eventLost_q <= 1'b1;
            end
        end
    end

    // shift engine
    logic              take;
    logic [STAGES-1:0] stage_q;
    logic [STAGES-1:0] latch_q;
    logic              strobeHeld_q;
    logic [W-1:0]      ev;

    assign drainSide.ready = !engineHold;
    assign take            = drainSide.valid && !engineHold;
    assign ev              = drainSide.data;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= shift_store_pkg::STAGE_RESET;
        end else if (take && ev[shift_store_pkg::BIT_RISE]) begin
            stage_q <= {stage_q[STAGES-2:0], ev[shift_store_pkg::BIT_DATA]};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cascade_out_rise <= shift_store_pkg::BIT_RESET;
        end else if (take && ev[shift_store_pkg::BIT_RISE]) begin
            cascade_out_rise <= stage_q[STAGES-2];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cascade_out_fall <= shift_store_pkg::BIT_RESET;
        end else if (take && ev[shift_store_pkg::BIT_FALL]) begin
            cascade_out_fall <= cascade_out_rise;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strobeHeld_q <= shift_store_pkg::BIT_RESET;
        end else if (take) begin
            strobeHeld_q <= ev[shift_store_pkg::BIT_STROBE];
        end
    end

    // transparent while strobe high, so latches track the stages a cycle behind
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            latch_q <= shift_store_pkg::LATCH_RESET;
        end else if (strobeHeld_q) begin
            latch_q <= stage_q;
        end
    end

    // output drivers; enable follows the pin directly, never the buffer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            parallel_outputs <= shift_store_pkg::LATCH_RESET;
            parallelEnable_n <= {STAGES{shift_store_pkg::OE_N_RESET}};
        end else begin
            parallel_outputs <= latch_q;
            parallelEnable_n <= {STAGES{!oeLevel_q}};
        end
    end
endmodule : shift_and_store_register

/* rtl/shift_store_pkg.sv */
// constants shared by the shift-and-store register and its event buffer
// assumes one 100 MHz clock and pins arriving from outside the clock domain
// Summary of operation
// - eight stages; each rising shift clock moves stages on, serial input enters first
// - a latch per stage follows its stage while strobe high, holds while low
// - output enable high drives the latch contents onto the parallel outputs
// - output enable low floats all parallel outputs regardless of strobe and clock
// - rising edge moves seventh stage into eighth and onto the rising cascade output
// - falling cascade output takes the rising cascade bit at the next falling edge
// - a falling edge changes only the falling cascade output
package shift_store_pkg;
    localparam int STAGE_COUNT   = 8;
    localparam int SYNC_DEPTH    = 3;
    localparam int FIFO_DEPTH    = 16;
    // event word layout
    localparam int EVENT_WIDTH   = 4;
    localparam int BIT_RISE      = 3;
    localparam int BIT_FALL      = 2;
    localparam int BIT_DATA      = 1;
    localparam int BIT_STROBE    = 0;
    // reset values
    localparam logic [7:0] STAGE_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic       BIT_RESET   = 1'h0;
    localparam logic       OE_N_RESET  = 1'h1;
    localparam logic [2:0] SYNC_RESET  = 3'h0;
endpackage : shift_store_pkg
